// *** core/csh_core_security_hardening.sv ***
// Security hardening logic: alarms, generators, fillers, timing and checks
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Two alarm outputs stay high every cycle their issue persists.
// - Severe alarm on check-code, PC, shadow, interface, integrity or protocol errors.
// - Mild alarm on generator lockup, taken illegal instructions and taken access or bus faults.
// - Constant-time mode fixes divide latency and equalises branch latency.
// - With filler enabled, fillers enter at random intervals, state unchanged.
// - Rate field picks interval 1-4 up to 1-64 real instructions.
// - Any other rate encoding is legal and still inserts fillers.
// - Generator a picks spacing and filler kind: add, multiply or bltu.
// - Filler operands come from generators b and c, not registers.
// - Each generator takes taps and reset seed from a parameter.
// - Software reseed writes load the generator; software avoids lockup seeds.
// - A locked generator raises mild alarm and reloads its reset seed.
// - Filler cycles count as cycles but never as retired instructions.
// - Shift-left hint to x0 runs random op if enabled, else nop.
// - The hint always counts as cycle and as retired instruction.
// - Register words carry a check code; read errors raise severe alarm.
// - PC check compares fetch PC with decode PC plus 2 or 4.
// - PC check recomputes jump, branch and return targets and decisions.
// - Any PC or decision mismatch pulses the severe alarm.
// - Critical CSRs keep complemented shadows, compared every cycle.
module csh_core_security_hardening #(
  parameter csh_pkg::csh_prng_config_type PRNG_A_CFG = csh_pkg::PRNG_A_DEFAULT,
  parameter csh_pkg::csh_prng_config_type PRNG_B_CFG = csh_pkg::PRNG_B_DEFAULT,
  parameter csh_pkg::csh_prng_config_type PRNG_C_CFG = csh_pkg::PRNG_C_DEFAULT,
  parameter int NUM_CSR = 8,
  parameter logic [NUM_CSR-1:0][31:0] CSR_RESET_VALUE = '0,
  parameter int DIV_FIXED_CYCLES = 35,
  parameter int BRANCH_TAKEN_CYCLES = 2,
  parameter int BRANCH_NOT_TAKEN_CYCLES = 1,
  parameter int CNT_W = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic constTimeEnable,
  input wire logic fillerInsertEnable,
  input wire logic [3:0] fillerRateSelect,
  input wire logic hintRandomizeEnable,
  input wire logic pcCheckEnable,
  input wire logic instrIntfErrNonAssoc,
  input wire logic dataIntfErrNonAssoc,
  input wire logic instrIntegrityFaultTaken,
  input wire logic loadIntegrityNmiTaken,
  input wire logic storeIntegrityNmiTaken,
  input wire logic busProtocolError,
  input wire logic instrAccessFaultTaken,
  input wire logic illegalInstrTaken,
  input wire logic loadAccessFaultTaken,
  input wire logic storeAccessFaultTaken,
  input wire logic instrBusFaultTaken,
  input wire logic loadBusFaultNmiTaken,
  input wire logic storeBusFaultNmiTaken,
  input wire logic [2:0] reseedWrite,
  input wire logic [31:0] reseedValue,
  input wire logic instrIssue,
  input wire logic fillerAccept,
  output logic fillerValid,
  output logic issueHold,
  output csh_pkg::csh_filler_op_type randomOp,
  output logic [31:0] randomOperandA,
  output logic [31:0] randomOperandB,
  input wire logic decodeValid,
  input wire logic [15:0] decodeInstr,
  output logic hintReplace,
  output logic hintNop,
  input wire logic opStart,
  input wire logic opIsDiv,
  input wire logic [csh_pkg::LAT_W-1:0] divDataCycles,
  input wire logic branchTaken,
  output logic opBusy,
  output logic opDone,
  input wire logic pcCheckValid,
  input wire csh_pkg::csh_xfer_kind_type xferKind,
  input wire logic [31:0] idPc,
  input wire logic idCompressed,
  input wire logic [31:0] ifPc,
  input wire logic [31:0] xferBase,
  input wire logic [31:0] xferOffset,
  input wire logic [31:0] branchOpA,
  input wire logic [31:0] branchOpB,
  input wire logic [2:0] branchCond,
  input wire logic coreTaken,
  input wire logic [NUM_CSR-1:0] csrWrite,
  input wire logic [31:0] csrWriteData,
  input wire logic [NUM_CSR-1:0][31:0] csrMainValue,
  input wire logic rfWriteEnable,
  input wire logic [4:0] rfWriteAddr,
  input wire logic [31:0] rfWriteData,
  input wire logic [csh_pkg::RF_WORD_W-1:0] rfInjectMask,
  input wire logic rfReadEnable,
  input wire logic [4:0] rfReadAddr,
  output logic [31:0] rfReadData,
  input wire logic retireValid,
  input wire logic retireIsFiller,
  output logic [CNT_W-1:0] cycleCount,
  output logic [CNT_W-1:0] retiredCount,
  output logic severe_alarm_out,
  output logic mild_alarm_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PRNG_A_CFG.prng_tap_coefficients == '0 || PRNG_A_CFG.prng_reset_seed == '0 ||
      PRNG_B_CFG.prng_tap_coefficients == '0 || PRNG_B_CFG.prng_reset_seed == '0 ||
      PRNG_C_CFG.prng_tap_coefficients == '0 || PRNG_C_CFG.prng_reset_seed == '0) begin : gBadCfg
    $error("generator configuration values must be non-zero");
  end
  if (DIV_FIXED_CYCLES < 1 || DIV_FIXED_CYCLES > 63 || BRANCH_TAKEN_CYCLES < 1 ||
      BRANCH_TAKEN_CYCLES > 62 || BRANCH_NOT_TAKEN_CYCLES < 1 ||
      BRANCH_NOT_TAKEN_CYCLES > 62 || NUM_CSR < 1 || CNT_W < 2) begin : gBadParam
    $error("latency, CSR count or counter width out of range");
  end

  localparam csh_pkg::csh_prng_config_type PRNG_CFG [3] = '{PRNG_A_CFG, PRNG_B_CFG, PRNG_C_CFG};
  localparam logic [csh_pkg::LAT_W-1:0] DIV_LAT = csh_pkg::LAT_W'(DIV_FIXED_CYCLES);
  localparam logic [csh_pkg::LAT_W-1:0] TAKEN_LAT = csh_pkg::LAT_W'(BRANCH_TAKEN_CYCLES);
  localparam logic [csh_pkg::LAT_W-1:0] NOT_TAKEN_LAT = csh_pkg::LAT_W'(BRANCH_NOT_TAKEN_CYCLES);
  localparam logic [csh_pkg::LAT_W-1:0] LAT_ONE = csh_pkg::LAT_W'(1);

  typedef struct packed {
    logic [2:0][31:0] prng;
    logic [csh_pkg::FILL_W-1:0] fillCnt;
    logic fillPending;
    csh_pkg::csh_filler_op_type fillOp;
    logic [31:0] opA;
    logic [31:0] opB;
    csh_pkg::csh_lat_state_type latState;
    logic [csh_pkg::LAT_W-1:0] latCnt;
    logic [NUM_CSR-1:0][31:0] shadow;
    logic [CNT_W-1:0] cycleCnt;
    logic [CNT_W-1:0] retiredCnt;
    logic severe;
    logic mild;
  } csh_state_type;

  csh_state_type state_q;
  csh_state_type state_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] prngStep(input logic [31:0] s, input logic [31:0] taps);
    return {1'b0, s[31:1]} ^ (s[0] ? taps : 32'h0000_0000);
  endfunction

  function automatic csh_pkg::csh_filler_op_type pickOp(input logic [1:0] r);
    case (r)
      2'h1: return csh_pkg::FILL_MUL;
      2'h2: return csh_pkg::FILL_BLTU;
      default: return csh_pkg::FILL_ADD;
    endcase
  endfunction

  function automatic logic branchDecision(input logic [2:0] cond, input logic [31:0] a,
                                          input logic [31:0] b);
    case (cond)
      3'h0: return a == b;
      3'h1: return a != b;
      3'h4: return $signed(a) < $signed(b);
      3'h5: return $signed(a) >= $signed(b);
      3'h6: return a < b;
      3'h7: return a >= b;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register file with check code
  // ----------------------------------------------------------------
  logic rfEccError;

  csh_regfile_ecc #(
    .WORDS(32),
    .ADDR_W(5)
  ) u_regfile (
    .clk(clk),
    .rst(rst),
    .writeEnable(rfWriteEnable),
    .writeAddr(rfWriteAddr),
    .writeData(rfWriteData),
    .injectMask(rfInjectMask),
    .readEnable(rfReadEnable),
    .readAddr(rfReadAddr),
    .readData(rfReadData),
    .eccError(rfEccError)
  );

  // ----------------------------------------------------------------
  // Combinational checks
  // ----------------------------------------------------------------
  logic [2:0] lockup;
  logic isHint;
  logic csrMismatch;
  logic pcMismatch;
  logic [31:0] expectPc;
  logic [31:0] stepPc;
  logic recomputedTaken;
  logic [csh_pkg::FILL_W-1:0] fillMask;
  logic [csh_pkg::LAT_W-1:0] opLatency;
  logic [csh_pkg::LAT_W-1:0] notTakenLat;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lockup[i] = state_q.prng[i] == 32'h0000_0000;
    end
    isHint = decodeValid && decodeInstr[1:0] == csh_pkg::HINT_QUADRANT &&
             decodeInstr[15:13] == csh_pkg::HINT_FUNCT3 &&
             decodeInstr[11:7] == csh_pkg::HINT_RD_ZERO &&
             {decodeInstr[12], decodeInstr[6:2]} != 6'h00;
    csrMismatch = 1'b0;
    for (int i = 0; i < NUM_CSR; i++) begin
      if (csrMainValue[i] != ~state_q.shadow[i]) csrMismatch = 1'b1;
    end
    stepPc = idPc + (idCompressed ? csh_pkg::PC_STEP_RVC : csh_pkg::PC_STEP_RV32);
    recomputedTaken = branchDecision(branchCond, branchOpA, branchOpB);
    case (xferKind)
      csh_pkg::XFER_BRANCH: expectPc = recomputedTaken ? idPc + xferOffset : stepPc;
      csh_pkg::XFER_JUMP: expectPc = (xferBase + xferOffset) & csh_pkg::JUMP_ALIGN_MASK;
      csh_pkg::XFER_TRAP_RETURN: expectPc = xferBase;
      default: expectPc = stepPc;
    endcase
    pcMismatch = pcCheckEnable && pcCheckValid && (ifPc != expectPc ||
                 (xferKind == csh_pkg::XFER_BRANCH && coreTaken != recomputedTaken));
    fillMask = {fillerRateSelect, csh_pkg::RATE_LOW_ONES};
    // Not-taken branches pay one more cycle while the PC check recomputes
    notTakenLat = NOT_TAKEN_LAT + (pcCheckEnable ? LAT_ONE : '0);
    if (opIsDiv) begin
      opLatency = constTimeEnable ? DIV_LAT : ((divDataCycles == '0) ? LAT_ONE : divDataCycles);
    end else if (constTimeEnable) begin
      opLatency = (TAKEN_LAT > notTakenLat) ? TAKEN_LAT : notTakenLat;
    end else begin
      opLatency = branchTaken ? TAKEN_LAT : notTakenLat;
    end
  end

  assign fillerValid = state_q.fillPending && fillerInsertEnable;
  assign issueHold = fillerValid;
  assign hintReplace = isHint && hintRandomizeEnable;
  assign hintNop = isHint && !hintRandomizeEnable;
  assign opBusy = state_q.latState == csh_pkg::LAT_BUSY;
  assign opDone = opBusy && state_q.latCnt == '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < 3; i++) begin
      if (reseedWrite[i]) begin
        state_d.prng[i] = reseedValue;
      end else if (lockup[i]) begin
        state_d.prng[i] = PRNG_CFG[i].prng_reset_seed;
      end else begin
        state_d.prng[i] = prngStep(state_q.prng[i], PRNG_CFG[i].prng_tap_coefficients);
      end
    end
    // Filler spacing counts real instructions from a random start
    if (!fillerInsertEnable || (fillerValid && fillerAccept)) begin
      state_d.fillPending = 1'b0;
      state_d.fillCnt = state_q.prng[0][csh_pkg::FILL_W-1:0] & fillMask;
    end else if (instrIssue && !state_q.fillPending) begin
      if (state_q.fillCnt == '0) begin
        state_d.fillPending = 1'b1;
      end else begin
        state_d.fillCnt = state_q.fillCnt - 1'b1;
      end
    end
    // Operands frozen while a filler waits to be taken
    if (!state_q.fillPending) begin
      state_d.fillOp = pickOp(state_q.prng[0][csh_pkg::FILL_W+1:csh_pkg::FILL_W]);
      state_d.opA = state_q.prng[1];
      state_d.opB = state_q.prng[2];
    end
    case (state_q.latState)
      csh_pkg::LAT_IDLE: begin
        if (opStart) begin
          state_d.latState = csh_pkg::LAT_BUSY;
          state_d.latCnt = opLatency - LAT_ONE;
        end
      end
      csh_pkg::LAT_BUSY: begin
        if (state_q.latCnt == '0) begin
          state_d.latState = csh_pkg::LAT_IDLE;
        end else begin
          state_d.latCnt = state_q.latCnt - LAT_ONE;
        end
      end
      default: state_d.latState = csh_pkg::LAT_IDLE;
    endcase
    for (int i = 0; i < NUM_CSR; i++) begin
      if (csrWrite[i]) state_d.shadow[i] = ~csrWriteData;
    end
    state_d.cycleCnt = state_q.cycleCnt + 1'b1;
    if (retireValid && !retireIsFiller) begin
      state_d.retiredCnt = state_q.retiredCnt + 1'b1;
    end
    state_d.severe = rfEccError || pcMismatch || csrMismatch || instrIntfErrNonAssoc ||
                     dataIntfErrNonAssoc || instrIntegrityFaultTaken ||
                     loadIntegrityNmiTaken || storeIntegrityNmiTaken ||
                     busProtocolError;
    state_d.mild = (|lockup) || instrAccessFaultTaken || illegalInstrTaken ||
                   loadAccessFaultTaken || storeAccessFaultTaken || instrBusFaultTaken ||
                   loadBusFaultNmiTaken || storeBusFaultNmiTaken;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
      state_q.prng <= {PRNG_C_CFG.prng_reset_seed, PRNG_B_CFG.prng_reset_seed,
                       PRNG_A_CFG.prng_reset_seed};
      state_q.shadow <= ~CSR_RESET_VALUE;
      state_q.fillOp <= csh_pkg::FILL_ADD;
      state_q.latState <= csh_pkg::LAT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign randomOp = state_q.fillOp;
  assign randomOperandA = state_q.opA;
  assign randomOperandB = state_q.opB;
  assign cycleCount = state_q.cycleCnt;
  assign retiredCount = state_q.retiredCnt;
  assign severe_alarm_out = state_q.severe;
  assign mild_alarm_out = state_q.mild;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CSR_SHADOW_ALARM: assert property (
    csrMismatch |=> severe_alarm_out)
    else $error("shadow mismatch did not raise severe alarm");

  AST_PC_MISMATCH_PULSE: assert property (
    pcMismatch |=> severe_alarm_out)
    else $error("pc mismatch pulse missing");

  AST_PC_ALARM: assert property (
    pcCheckEnable && pcCheckValid && xferKind == csh_pkg::XFER_SEQ && ifPc != stepPc
    |=> severe_alarm_out)
    else $error("sequential pc error not flagged");

  AST_LOCKUP_RELOAD: assert property (
    state_q.prng[0] == '0 && !reseedWrite[0]
    |=> state_q.prng[0] == PRNG_A_CFG.prng_reset_seed && mild_alarm_out)
    else $error("locked generator not reloaded with alarm");

  AST_RESEED_LOAD: assert property (
    reseedWrite[1] |=> state_q.prng[1] == $past(reseedValue))
    else $error("reseed value not loaded");

  AST_FILLER_SPACING: assert property (
    fillerValid && fillerAccept |=> !fillerValid && state_q.fillCnt <= $past(fillMask))
    else $error("filler spacing outside selected interval");

  AST_FILLER_OPERANDS: assert property (
    !state_q.fillPending |=> randomOperandA == $past(state_q.prng[1]) &&
                             randomOperandB == $past(state_q.prng[2]))
    else $error("filler operands not from generators");

  AST_FILLER_NOT_RETIRED: assert property (
    retireValid && retireIsFiller |=> $stable(retiredCount) &&
    cycleCount == $past(cycleCount) + 1'b1)
    else $error("filler counted as retired");

  AST_DIV_FIXED: assert property (
    !opBusy && opStart && opIsDiv && constTimeEnable |=>
    opBusy && state_q.latCnt == DIV_LAT - LAT_ONE)
    else $error("divide latency not fixed");

  AST_HINT_COUNTS: assert property (
    retireValid && !retireIsFiller |=> retiredCount == $past(retiredCount) + 1'b1)
    else $error("hint or instruction not counted");

  AST_ECC_ALARM: assert property (
    rfEccError |=> severe_alarm_out)
    else $error("check code error did not raise alarm");

endmodule

`default_nettype wire

// *** core/csh_regfile_ecc.sv ***
// Register file with a stored check code per word and checked reads
`timescale 1ns/1ps
`default_nettype none

module csh_regfile_ecc #(
  parameter int WORDS = 32,
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic writeEnable,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [csh_pkg::XLEN-1:0] writeData,
  input wire logic [csh_pkg::RF_WORD_W-1:0] injectMask,
  input wire logic readEnable,
  input wire logic [ADDR_W-1:0] readAddr,
  output logic [csh_pkg::XLEN-1:0] readData,
  output logic eccError
);

  if (WORDS < 2 || WORDS > (1 << ADDR_W)) begin : gBadSize
    $error("csh_regfile_ecc: WORDS does not fit ADDR_W");
  end

  typedef struct packed {
    logic [WORDS-1:0][csh_pkg::RF_WORD_W-1:0] mem;
    logic [csh_pkg::XLEN-1:0] rdata;
    logic err;
  } csh_rf_state_type;

  csh_rf_state_type state_q;
  csh_rf_state_type state_d;

  always_comb begin
    logic [csh_pkg::RF_WORD_W-1:0] word;
    word = '0;
    state_d = state_q;
    state_d.err = 1'b0;
    // Injection mask lets a fault be planted in the stored word
    if (writeEnable) begin
      state_d.mem[writeAddr] = {csh_pkg::eccEncode(writeData), writeData} ^ injectMask;
    end
    if (readEnable) begin
      word = state_q.mem[readAddr];
      state_d.rdata = word[csh_pkg::XLEN-1:0];
      state_d.err = csh_pkg::eccEncode(word[csh_pkg::XLEN-1:0]) !=
                    word[csh_pkg::RF_WORD_W-1:csh_pkg::XLEN];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign readData = state_q.rdata;
  assign eccError = state_q.err;

endmodule

`default_nettype wire

// *** include/csh_pkg.sv ***
// Shared types and constants of the core security hardening block
package csh_pkg;

  // ----------------------------------------------------------------
  // Generator configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prng_tap_coefficients;
    logic [31:0] prng_reset_seed;
  } csh_prng_config_type;

  localparam csh_prng_config_type PRNG_A_DEFAULT = '{32'h8000_0057, 32'h0000_0001};
  localparam csh_prng_config_type PRNG_B_DEFAULT = '{32'h8000_0057, 32'h0000_0002};
  localparam csh_prng_config_type PRNG_C_DEFAULT = '{32'h8000_0057, 32'h0000_0003};

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int ECC_W = 6;
  localparam int RF_WORD_W = XLEN + ECC_W;
  localparam int LAT_W = 6;
  localparam int FILL_W = 6;
  localparam logic [1:0] RATE_LOW_ONES = 2'h3;
  localparam logic [31:0] PC_STEP_RVC = 32'h0000_0002;
  localparam logic [31:0] PC_STEP_RV32 = 32'h0000_0004;
  localparam logic [31:0] JUMP_ALIGN_MASK = 32'hFFFF_FFFE;

  // Compressed shift-left hint fields
  localparam logic [1:0] HINT_QUADRANT = 2'h2;
  localparam logic [2:0] HINT_FUNCT3 = 3'h0;
  localparam logic [4:0] HINT_RD_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FILL_ADD = 2'h0,
    FILL_MUL = 2'h1,
    FILL_BLTU = 2'h3
  } csh_filler_op_type;

  typedef enum logic [1:0] {
    XFER_SEQ = 2'h0,
    XFER_BRANCH = 2'h1,
    XFER_JUMP = 2'h3,
    XFER_TRAP_RETURN = 2'h2
  } csh_xfer_kind_type;

  typedef enum logic {
    LAT_IDLE = 1'b0,
    LAT_BUSY = 1'b1
  } csh_lat_state_type;

  // ----------------------------------------------------------------
  // Check code: distance-3 code, every column distinct, weight >= 2
  // ----------------------------------------------------------------
  function automatic logic [ECC_W-1:0] eccColumn(input int idx);
    int n;
    logic [ECC_W-1:0] col;
    n = 0;
    col = '0;
    for (int k = 3; k < 64; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == idx) col = k[ECC_W-1:0];
        n++;
      end
    end
    return col;
  endfunction

  function automatic logic [ECC_W-1:0] eccEncode(input logic [XLEN-1:0] data);
    logic [ECC_W-1:0] code;
    code = '0;
    for (int i = 0; i < XLEN; i++) begin
      if (data[i]) code = code ^ eccColumn(i);
    end
    return code;
  endfunction

endpackage

// *** sim/csh_core_security_hardening_tb.sv ***
// Self-checking bench of the core security hardening block
`timescale 1ns/1ps
`default_nettype none
module csh_core_security_hardening_tb;
  logic clk = 0, rst = 1, eraseReq, fillerValid, issueHold, hintReplace, hintNop, opBusy, opDone;
  logic severe_alarm_out, mild_alarm_out, instrIntfErrNonAssoc, dataIntfErrNonAssoc;
  logic instrIntegrityFaultTaken, loadIntegrityNmiTaken, storeIntegrityNmiTaken, busProtocolError;
  logic instrAccessFaultTaken, illegalInstrTaken, loadAccessFaultTaken, storeAccessFaultTaken;
  logic instrBusFaultTaken, loadBusFaultNmiTaken, storeBusFaultNmiTaken;
  logic constTimeEnable = 0, fillerInsertEnable = 0, hintRandomizeEnable = 0, pcCheckEnable = 0;
  logic instrIssue = 0, fillerAccept = 0, decodeValid = 0, opStart = 0, opIsDiv = 0;
  logic branchTaken = 0, pcCheckValid = 0, idCompressed = 0, coreTaken = 0, rfWriteEnable = 0;
  logic rfReadEnable = 0, retireValid = 0, retireIsFiller = 0;
  logic [15:0] decodeInstr = '0;
  logic [12:0] cause = '0;
  logic [3:0] fillerRateSelect = '0;
  logic [2:0] reseedWrite = '0, branchCond = '0;
  logic [4:0] rfWriteAddr = '0, rfReadAddr = '0;
  logic [csh_pkg::LAT_W-1:0] divDataCycles = '0;
  logic [31:0] reseedValue = '0, idPc = '0, ifPc = '0, xferBase = '0, xferOffset = '0, d;
  logic [31:0] branchOpA = '0, branchOpB = '0, csrWriteData = '0, rfWriteData = '0;
  logic [31:0] randomOperandA, randomOperandB, rfReadData;
  logic [7:0] csrWrite = '0;
  logic [7:0][31:0] csrMainValue = '0;
  logic [csh_pkg::RF_WORD_W-1:0] rfInjectMask = '0;
  logic [63:0] cycleCount, retiredCount, c0, r0;
  csh_pkg::csh_xfer_kind_type xferKind = csh_pkg::XFER_SEQ;
  csh_pkg::csh_filler_op_type randomOp;
  int bad_count = 0, n_compared = 0, n, m;
  assign {storeBusFaultNmiTaken, loadBusFaultNmiTaken, instrBusFaultTaken, storeAccessFaultTaken,
    loadAccessFaultTaken, illegalInstrTaken, instrAccessFaultTaken, busProtocolError,
    storeIntegrityNmiTaken, loadIntegrityNmiTaken, instrIntegrityFaultTaken, dataIntfErrNonAssoc,
    instrIntfErrNonAssoc} = cause;
  csh_core_security_hardening dut (.*);
  csh_incident_responder far (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Expected latency from the mode bits
  function automatic int lat(input logic pc, ct, dv, tk, input int dc);
    if (dv) return ct ? 35 : (dc == 0 ? 1 : dc);
    return (ct || tk) ? 2 : 1 + pc;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(16827));
    tick(5);
    rst = 0;
    chk({severe_alarm_out, mild_alarm_out, eraseReq}, 0);
    chk(retiredCount, 0);
    for (int i = 0; i < 13; i++) begin
      cause = 13'h1 << i;
      repeat (3) begin
        tick(1);
        chk({severe_alarm_out, mild_alarm_out}, i < 6 ? 2 : 1);
      end
      cause = '0;
      tick(1);
      chk({severe_alarm_out, mild_alarm_out}, 0);
    end
    chk(eraseReq, 1);
    $display("done: alarms");
    for (int i = 0; i < 6; i++) begin
      reseedWrite = 3'h1 << (i % 3);
      reseedValue = i < 3 ? 32'h0 : ($urandom() | 32'h1);
      tick(1);
      reseedWrite = '0;
      chk(mild_alarm_out, 0);
      tick(1);
      chk(mild_alarm_out, i < 3);
      if (i > 3) chk(i == 4 ? randomOperandA : randomOperandB, reseedValue);
      tick(1);
      chk(mild_alarm_out, 0);
      if (i == 4) chk(randomOperandA, (reseedValue >> 1) ^ (reseedValue[0] ?
                      csh_pkg::PRNG_B_DEFAULT.prng_tap_coefficients : 0));
    end
    $display("done: reseed");
    for (int i = 0; i < 16; i++) begin
      {pcCheckEnable, constTimeEnable, opIsDiv, branchTaken} = i[3:0];
      divDataCycles = (csh_pkg::LAT_W)'($urandom_range(1, 40));
      opStart = 1;
      tick(1);
      opStart = 0;
      n = 1;
      while (opDone !== 1 && n < 100) begin
        tick(1);
        n++;
      end
      chk(n, lat(i[3], i[2], i[1], i[0], divDataCycles));
      tick(1);
    end
    $display("done: latency");
    pcCheckValid = 1;
    pcCheckEnable = 1;
    idPc = $urandom() & 32'hFFFF_FFF0;
    for (int i = 0; i < 4; i++) begin
      ifPc = idPc + (i[0] ? 32'h4 : 32'h2);
      idCompressed = i[1];
      tick(1);
      chk(severe_alarm_out, i[0] == i[1]);
    end
    xferKind = csh_pkg::XFER_BRANCH;
    xferOffset = 32'h0000_0040;
    ifPc = idPc + xferOffset;
    for (int i = 0; i < 2; i++) begin
      coreTaken = i[0];
      tick(1);
      chk(severe_alarm_out, !i[0]);
    end
    xferKind = csh_pkg::XFER_JUMP;
    xferBase = idPc;
    xferOffset = 32'h0000_0041;
    tick(1);
    chk(severe_alarm_out, 0);
    xferKind = csh_pkg::XFER_SEQ;
    pcCheckValid = 0;
    d = $urandom();
    csrWrite = 8'h04;
    csrWriteData = d;
    tick(1);
    csrWrite = '0;
    csrMainValue[2] = d;
    tick(1);
    chk(severe_alarm_out, 0);
    csrMainValue[2] = d ^ (32'h1 << $urandom_range(0, 31));
    tick(1);
    chk(severe_alarm_out, 1);
    csrMainValue[2] = d;
    rfWriteAddr = 5'h03;
    rfReadAddr = 5'h03;
    rfWriteData = d;
    for (int i = 0; i < 3; i++) begin
      rfWriteEnable = 1;
      rfInjectMask = (csh_pkg::RF_WORD_W)'(i == 2 ? 3 : i) << $urandom_range(0, 36);
      tick(1);
      rfWriteEnable = 0;
      rfInjectMask = '0;
      rfReadEnable = 1;
      tick(1);
      rfReadEnable = 0;
      if (i == 0) chk(rfReadData, d);
      m = 0;
      repeat (3) begin
        tick(1);
        if (severe_alarm_out === 1'b1) m = 1;
      end
      chk(m, i != 0);
    end
    $display("done: checks");
    c0 = cycleCount;
    r0 = retiredCount;
    m = 0;
    repeat (10) begin
      retireValid = 1;
      retireIsFiller = 1'($urandom_range(0, 1));
      m += !retireIsFiller;
      tick(1);
    end
    retireValid = 0;
    chk(cycleCount - c0, 10);
    chk(retiredCount - r0, m);
    decodeValid = 1;
    for (int i = 0; i < 6; i++) begin
      hintRandomizeEnable = i[0];
      decodeInstr = i < 2 ? 16'h1002 : (i < 4 ? 16'h0002 : 16'h0086);
      #1;
      chk({hintReplace, hintNop}, i < 2 ? (i[0] ? 2 : 1) : 0);
      tick(1);
    end
    $display("done: counters and hint");
    for (int i = 0; i < 8; i++) begin
      fillerInsertEnable = 0;
      fillerRateSelect = 4'($urandom_range(0, 15));
      tick(1);
      fillerInsertEnable = 1;
      instrIssue = 1;
      n = 0;
      while (fillerValid !== 1 && n < 200) begin
        tick(1);
        n++;
      end
      instrIssue = 0;
      chk(n >= 1 && n <= {fillerRateSelect, 2'b11} + 1, 1);
      chk({issueHold, randomOp != csh_pkg::csh_filler_op_type'(2'h2)}, 2'h3);
      fillerAccept = 1;
      tick(1);
      fillerAccept = 0;
      chk(fillerValid, 0);
    end
    $display("done: fillers");
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 500 cycles the tests take
  initial begin
    tick(4000);
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** sim/csh_incident_responder.sv ***
// Far-side model of the system incident response logic
`timescale 1ns/1ps
`default_nettype none
module csh_incident_responder (
  input wire logic clk,
  input wire logic rst,
  input wire logic severe_alarm_out,
  output logic eraseReq
);
  // Latches an erase request on any severe alarm cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eraseReq <= 1'b0;
    end else if (severe_alarm_out) begin
      eraseReq <= 1'b1;
    end
  end
endmodule
`default_nettype wire
